// >>> core/dups_pin_select.sv
// Top of the dual channel pin function select with APB registers.
// Assumes a zero-wait APB master on pclk and a serial core per channel.
// Notes on behaviour
// RULE1 - Infrared bit clear: channel pins use the plain serial line.
// RULE2 - Plain mode: transmit pin high in reset and when idle.
// RULE3 - Infrared bit set: pins go to infrared encoder and decoder.
// RULE4 - Infrared mode: transmit pin low when idle, pulses only high.
// RULE5 - Receive idles high plainly; infrared input may be inverted by software.
// RULE6 - Output-two bit set: interrupt line active, output-two low; else tri-state, high.
// RULE7 - System must not use output-two as general output while interrupt used.
// RULE8 - Bus select high: shared pin is interrupt; low: channel A transmit ready.
// RULE9 - Bus select picks host bus style; defaults high.
// RULE10 - Each channel has active-low transmit ready output for DMA.
// RULE11 - Each channel has active-low receive ready output for DMA.
// RULE12 - Request-to-send is a general output and gated by auto flow control.
// RULE13 - Clear-to-send readable as input; gates transmit under auto flow control.
// RULE14 - Half-duplex control drives request-to-send as line direction.
// RULE15 - Terminal-ready, set-ready, carrier, ring pins usable as general bits.
// RULE16 - Reset pin polarity follows bus select; holds transmit high, ignores receive.
// RULE17 - Each channel's settings affect only that channel's pins.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module dups_pin_select
	import dups_pkg::*;
(
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial cores
	input wire dups_core_t [NCH-1:0] core_i,
	output dups_to_core_t [NCH-1:0] to_core,
	// Channel pins
	input wire dups_pin_in_t [NCH-1:0] pin_i,
	output dups_pin_out_t [NCH-1:0] pin_o,
	// Shared pin of channel A and channel B interrupt line
	output logic irq_line_a,
	output logic irq_line_a_oe,
	output logic irq_line_b,
	output logic irq_line_b_oe,
	// Bus style and reset pins
	input wire logic bus_sel_pin,
	input wire logic reset_pin,
	output logic host_style_first,
	output logic chip_rst
);
	logic [NCH-1:0][7:0] mcr_r;
	logic [NCH-1:0][7:0] efr_r;
	logic [NCH-1:0][7:0] ier_r;
	logic [NCH-1:0][7:0] cfg_r;
	dups_pin_in_t [NCH-1:0] pin_s;
	logic bus_first;
	logic rst_pin_s;
	logic [2:0] rst_cnt_r;
	logic [31:0] prdata_r;

	// All pin inputs pass two flops; bus select resets high like its pull-up
	dups_sync #(
		.WIDTH(5 * NCH + 2),
		.RST_VAL({PIN_IN_RST, PIN_IN_RST, 1'b1, 1'b0})
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.d({pin_i, bus_sel_pin, reset_pin}),
		.q({pin_s, bus_first, rst_pin_s})
	); // see RULE9

	assign host_style_first = bus_first; // see RULE9
	wire rst_act = bus_first ? rst_pin_s : ~rst_pin_s; // see RULE16
	// Stretch so even a minimum pulse resets for the full time
	assign chip_rst = rst_act | (rst_cnt_r != 3'h0); // see RULE16

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rst_cnt_r <= 3'h0;
		else if (ce)
			rst_cnt_r <= rst_act ? RST_CYC_W : rst_cnt_r - (rst_cnt_r != 3'h0 ? 3'h1 : 3'h0);
	end

	// Address decode
	wire [7:0] addr = paddr[7:0];
	wire hi_zero = paddr[31:8] == 24'h0;
	wire ch_sel = addr[5];
	wire [7:0] sub = {3'h0, addr[4:0]};
	wire in_chan = hi_zero && addr[7:6] == 2'b00;
	wire hit_mcr = in_chan && sub == OFF_MCR;
	wire hit_efr = in_chan && sub == OFF_EFR;
	wire hit_ier = in_chan && sub == OFF_IER;
	wire hit_cfg = in_chan && sub == OFF_CFG;
	wire hit_stat = in_chan && sub == OFF_STAT;
	wire hit_glb = hi_zero && addr == OFF_GLB;
	wire mapped = hit_mcr | hit_efr | hit_ier | hit_cfg | hit_stat | hit_glb;
	wire access = psel & penable;
	wire wr_en = access & pwrite & mapped;
	// Status register is read-only; a write to it is accepted and dropped

	assign pready = 1'b1;
	assign pslverr = access & ~mapped;
	assign prdata = prdata_r;

	// General input bits read active high
	wire dups_pin_in_t sel_pin = pin_s[ch_sel];
	wire [7:0] stat_v = {3'h0, sel_pin.serial_in, ~sel_pin.ri_n, ~sel_pin.cd_n,
		~sel_pin.dsr_n, ~sel_pin.cts_n}; // see RULE13 see RULE15
	wire [7:0] rd_v = hit_mcr ? mcr_r[ch_sel] : hit_efr ? efr_r[ch_sel]
		: hit_ier ? ier_r[ch_sel] : hit_cfg ? cfg_r[ch_sel]
		: hit_stat ? stat_v : hit_glb ? {6'h0, chip_rst, bus_first} : 8'h00;

	// Read data is captured in the setup cycle so it leaves a flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= 32'h0;
		else if (ce && psel && !penable)
			prdata_r <= {24'h0, rd_v};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mcr_r <= '0;
			efr_r <= '0;
			ier_r <= '0;
			cfg_r <= '0;
		end
		else if (ce)
		begin
			for (int c = 0; c < NCH; c++)
			begin
				if (chip_rst)
				begin
					mcr_r[c] <= REG_RST;
					efr_r[c] <= REG_RST;
					ier_r[c] <= REG_RST;
					cfg_r[c] <= REG_RST;
				end
				else if (wr_en && ch_sel == c[0]) // see RULE17
				begin
					if (hit_mcr)
						mcr_r[c] <= pwdata[7:0];
					if (hit_efr)
						efr_r[c] <= pwdata[7:0];
					if (hit_ier)
						ier_r[c] <= pwdata[7:0];
					if (hit_cfg)
						cfg_r[c] <= pwdata[7:0];
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_chan
			dups_chan u_chan (
				.pclk(pclk),
				.presetn(presetn),
				.ce(ce),
				.hold(chip_rst),
				.modem_control_reg(mcr_r[g]),
				.enhanced_feature_reg(efr_r[g]),
				.interrupt_enable_reg(ier_r[g]),
				.cfg(cfg_r[g]),
				.core_i(core_i[g]),
				.pin_i(pin_s[g]),
				.pin_o(pin_o[g]),
				.to_core(to_core[g])
			); // see RULE17
		end
	endgenerate

	// Shared pin: interrupt in first bus style, transmit ready otherwise
	assign irq_line_a = bus_first ? pin_o[0].irq_o : pin_o[0].txrdy_n; // see RULE8
	assign irq_line_a_oe = bus_first ? pin_o[0].irq_oe : 1'b1; // see RULE8
	assign irq_line_b = pin_o[1].irq_o;
	assign irq_line_b_oe = pin_o[1].irq_oe; // see RULE6

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_tx_plain_idle: assert property (ce && !chip_rst && !mcr_r[0][MCR_IR]
		&& !core_i[0].tx_busy |=> pin_o[0].serial_out) // see RULE2
		else $error("plain idle transmit not high");
	a_tx_plain_route: assert property (ce && !chip_rst && !mcr_r[1][MCR_IR]
		&& core_i[1].tx_busy |=> pin_o[1].serial_out == $past(core_i[1].tx_bit)) // see RULE1
		else $error("plain transmit bit not routed");
	a_tx_ir_idle: assert property (ce && !chip_rst && mcr_r[0][MCR_IR]
		&& !core_i[0].tx_busy |=> !pin_o[0].serial_out) // see RULE4
		else $error("infrared idle transmit not low");
	a_tx_ir_route: assert property (ce && !chip_rst && mcr_r[1][MCR_IR]
		&& core_i[1].tx_busy |=> pin_o[1].serial_out == $past(core_i[1].ir_tx)) // see RULE3
		else $error("infrared pulse not routed");
	a_rx_ir_invert: assert property (ce && !chip_rst && mcr_r[0][MCR_IR]
		|=> to_core[0].rx_ir == $past(pin_s[0].serial_in ^ cfg_r[0][CFG_RXINV])) // see RULE5
		else $error("infrared receive inversion wrong");
	a_op2_irq_pair: assert property (ce && !chip_rst |=> pin_o[1].output_two_n
		== !$past(mcr_r[1][MCR_OP2]) && irq_line_b_oe == $past(mcr_r[1][MCR_OP2])) // see RULE6
		else $error("output two and interrupt enable disagree");
	a_shared_txrdy: assert property (!bus_first && ce && !chip_rst
		|=> irq_line_a == !$past(core_i[0].tx_rdy) && irq_line_a_oe) // see RULE8
		else $error("shared pin not transmit ready");
	a_rxrdy_level: assert property (ce && !chip_rst
		|=> pin_o[1].rxrdy_n == !$past(core_i[1].rx_rdy)) // see RULE11
		else $error("receive ready level wrong");
	a_cts_gate: assert property (ce && !chip_rst && efr_r[0][EFR_ACTS]
		&& ier_r[0][IER_ACTS] && pin_s[0].cts_n |=> !to_core[0].tx_allow) // see RULE13
		else $error("transmit allowed while clear to send off");
	a_rts_hdx_dir: assert property (ce && !chip_rst && cfg_r[0][CFG_HDX]
		|=> pin_o[0].request_send_n == !$past(core_i[0].hdx_drive)) // see RULE14
		else $error("direction output wrong");
	a_reset_hold: assert property (ce && rst_act |=> chip_rst ##1 chip_rst
		&& pin_o[0].serial_out && pin_o[1].serial_out) // see RULE16
		else $error("reset does not hold transmit high");
	a_chan_isolate: assert property (ce && wr_en && !ch_sel
		|=> $stable(mcr_r[1]) && $stable(cfg_r[1])) // see RULE17
		else $error("channel A write changed channel B");

	c_ir_send: cover property (mcr_r[0][MCR_IR] && core_i[0].tx_busy ##1 pin_o[0].serial_out);
	c_shared_irq: cover property (bus_first && irq_line_a_oe && irq_line_a);
	c_reset_pulse: cover property ($rose(rst_act) ##1 $fell(rst_act) ##[1:8] !chip_rst);
endmodule : dups_pin_select
`default_nettype wire

// >>> core/dups_pkg.sv
// Package for the dual serial channel pin function select block.
// Assumes a single pclk domain and an APB master with 32-bit data.
package dups_pkg;
	localparam int NCH = 2;
	// Register byte offsets (channel B adds OFF_CHB)
	localparam logic [7:0] OFF_MCR = 8'h00;
	localparam logic [7:0] OFF_EFR = 8'h04;
	localparam logic [7:0] OFF_IER = 8'h08;
	localparam logic [7:0] OFF_CFG = 8'h0C;
	localparam logic [7:0] OFF_STAT = 8'h10;
	localparam logic [7:0] OFF_CHB = 8'h20;
	localparam logic [7:0] OFF_GLB = 8'h40;
	localparam logic [7:0] REG_RST = 8'h00;
	// Field positions
	localparam int MCR_DTR = 0;
	localparam int MCR_RTS = 1;
	localparam int MCR_OP2 = 3;
	localparam int MCR_IR = 6;
	localparam int EFR_ARTS = 6;
	localparam int EFR_ACTS = 7;
	localparam int IER_ARTS = 6;
	localparam int IER_ACTS = 7;
	localparam int CFG_RXINV = 0;
	localparam int CFG_HDX = 1;
	// Timing
	localparam int CLK_NS = 10;
	localparam int RST_MIN_NS = 40;
	localparam int RST_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [2:0] RST_CYC_W = 3'(RST_CYC);
	// Signals from the channel's serial core (same clock)
	typedef struct packed {
		logic tx_bit;
		logic tx_busy;
		logic ir_tx;
		logic tx_rdy;
		logic rx_rdy;
		logic irq;
		logic rts_hold;
		logic hdx_drive;
	} dups_core_t;
	// Modem and serial pins in, already synchronised
	typedef struct packed {
		logic serial_in;
		logic cts_n;
		logic dsr_n;
		logic cd_n;
		logic ri_n;
	} dups_pin_in_t;
	typedef struct packed {
		logic serial_out;
		logic request_send_n;
		logic terminal_ready_n;
		logic output_two_n;
		logic irq_o;
		logic irq_oe;
		logic txrdy_n;
		logic rxrdy_n;
	} dups_pin_out_t;
	typedef struct packed {
		logic rx_uart;
		logic rx_ir;
		logic tx_allow;
	} dups_to_core_t;
	localparam logic [7:0] PIN_OUT_RST = 8'hF3;
	localparam logic [2:0] TO_CORE_RST = 3'h4;
	localparam logic [4:0] PIN_IN_RST = 5'h1F;
endpackage : dups_pkg

// >>> core/dups_sync.sv
// Two-flop synchroniser for a bus of independent level inputs.
// Assumes each bit is a slow level; no multi-bit coherence is given.
`timescale 1ns/1ns
`default_nettype none
module dups_sync
	import dups_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
)(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Data
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_r <= RST_VAL;
			q <= RST_VAL;
		end
		else if (ce)
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : dups_sync
`default_nettype wire

// >>> core/dups_chan.sv
// One channel's pin function select: line or infrared, modem pins.
// Assumes synchronised pin inputs and core signals on pclk.
`timescale 1ns/1ns
`default_nettype none
module dups_chan
	import dups_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic hold,
	// Channel registers
	input wire logic [7:0] modem_control_reg,
	input wire logic [7:0] enhanced_feature_reg,
	input wire logic [7:0] interrupt_enable_reg,
	input wire logic [7:0] cfg,
	// Core and pins
	input wire dups_core_t core_i,
	input wire dups_pin_in_t pin_i,
	output dups_pin_out_t pin_o,
	output dups_to_core_t to_core
);
	wire ir = modem_control_reg[MCR_IR];
	wire auto_rts = enhanced_feature_reg[EFR_ARTS] & interrupt_enable_reg[IER_ARTS];
	wire auto_cts = enhanced_feature_reg[EFR_ACTS] & interrupt_enable_reg[IER_ACTS];
	wire rts_req = modem_control_reg[MCR_RTS];
	// Infrared idles low, plain line idles high; reset forces high
	wire tx_nxt = hold | (ir ? (core_i.tx_busy & core_i.ir_tx)
		: (~core_i.tx_busy | core_i.tx_bit)); // see RULE1 see RULE2 see RULE3 see RULE4
	// Direction control wins over flow control on the shared pin
	wire rts_n_nxt = cfg[CFG_HDX] ? ~core_i.hdx_drive
		: ~(rts_req & ~(auto_rts & core_i.rts_hold)); // see RULE12 see RULE14
	dups_pin_out_t po_nxt;
	dups_to_core_t tc_nxt;
	assign po_nxt.serial_out = tx_nxt;
	assign po_nxt.request_send_n = hold | rts_n_nxt;
	assign po_nxt.terminal_ready_n = hold | ~modem_control_reg[MCR_DTR]; // see RULE15
	assign po_nxt.output_two_n = hold | ~modem_control_reg[MCR_OP2]; // see RULE6
	assign po_nxt.irq_o = core_i.irq;
	assign po_nxt.irq_oe = ~hold & modem_control_reg[MCR_OP2]; // see RULE6
	assign po_nxt.txrdy_n = hold | ~core_i.tx_rdy; // see RULE10
	assign po_nxt.rxrdy_n = hold | ~core_i.rx_rdy; // see RULE11
	// Receive input is ignored in reset: decoders see their idle level
	assign tc_nxt.rx_uart = hold | ir | pin_i.serial_in; // see RULE5
	assign tc_nxt.rx_ir = ~hold & ir & (pin_i.serial_in ^ cfg[CFG_RXINV]); // see RULE5
	assign tc_nxt.tx_allow = ~hold & (~auto_cts | ~pin_i.cts_n); // see RULE13
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_o <= dups_pin_out_t'(PIN_OUT_RST);
			to_core <= dups_to_core_t'(TO_CORE_RST);
		end
		else if (ce)
		begin
			pin_o <= po_nxt;
			to_core <= tc_nxt;
		end
	end
endmodule : dups_chan
`default_nettype wire

// >>> verification/dups_far_model.sv
// Far-side model: serial cores and line transceivers of both channels.
// Assumes the bench supplies the levels; they change just after pclk.
`timescale 1ns/1ns
`default_nettype none
module dups_far_model
	import dups_pkg::*;
(
	// Clock
	input wire logic pclk,
	// Bench control
	input wire logic [NCH-1:0] ir_mode,
	input wire logic line_idle,
	input wire dups_core_t [NCH-1:0] core_set,
	input wire dups_pin_in_t [NCH-1:0] pin_set,
	// Toward the design
	output var dups_core_t [NCH-1:0] core_i,
	output var dups_pin_in_t [NCH-1:0] pin_i
);
	// One driver only: values appear at the first edge, while reset still holds
	always @(posedge pclk)
	begin
		core_i <= core_set;
		pin_i <= pin_set;
		// Idle receive level: high on the plain line, low for infrared pulses
		for (int c = 0; c < NCH; c++)
			if (line_idle)
				pin_i[c].serial_in <= !ir_mode[c];
	end
endmodule : dups_far_model
`default_nettype wire

// >>> verification/dual_uart_pin_function_select_tb.sv
// Self-checking bench for the dual channel pin function select.
// Assumes the far-side model and a zero-wait APB slave.
`timescale 1ns/1ns
`default_nettype none
module dual_uart_pin_function_select_tb
	import dups_pkg::*;
;
	logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
	logic pready, pslverr, irq_line_a, irq_line_a_oe, irq_line_b, irq_line_b_oe;
	logic host_style_first, chip_rst, err;
	logic bus_sel_pin = 1, reset_pin = 0, line_idle = 0;
	logic [NCH-1:0] ir_mode = '0;
	dups_core_t [NCH-1:0] core_set = '0, core_i;
	dups_pin_in_t [NCH-1:0] pin_set = '1, pin_i;
	dups_to_core_t [NCH-1:0] to_core;
	dups_pin_out_t [NCH-1:0] pin_o;
	logic [7:0] rg [NCH][4];
	int miscompares = 0, n_tests = 0;
	always #5 pclk = ~pclk;
	dups_far_model far (.pclk(pclk), .ir_mode(ir_mode), .line_idle(line_idle),
		.core_set(core_set), .pin_set(pin_set), .core_i(core_i), .pin_i(pin_i));
	dups_pin_select dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .core_i(core_i),
		.to_core(to_core), .pin_i(pin_i), .pin_o(pin_o), .irq_line_a(irq_line_a),
		.irq_line_a_oe(irq_line_a_oe), .irq_line_b(irq_line_b),
		.irq_line_b_oe(irq_line_b_oe), .bus_sel_pin(bus_sel_pin),
		.reset_pin(reset_pin), .host_style_first(host_style_first), .chip_rst(chip_rst));
	task give_verdict;
		$display("Compared %0d, mismatched %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val
	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic dups_pin_out_t pexp(input logic [7:0] m, e, i, c, input dups_core_t k);
		pexp.serial_out = m[MCR_IR] ? (k.tx_busy & k.ir_tx) : (!k.tx_busy | k.tx_bit);
		pexp.request_send_n = c[CFG_HDX] ? !k.hdx_drive
			: !(m[MCR_RTS] & !(e[EFR_ARTS] & i[IER_ARTS] & k.rts_hold));
		pexp.terminal_ready_n = !m[MCR_DTR];
		pexp.output_two_n = !m[MCR_OP2];
		pexp.irq_o = k.irq;
		pexp.irq_oe = m[MCR_OP2];
		pexp.txrdy_n = !k.tx_rdy;
		pexp.rxrdy_n = !k.rx_rdy;
	endfunction : pexp
	function automatic dups_to_core_t cexp(input logic [7:0] m, e, i, c, input dups_pin_in_t q);
		cexp.rx_uart = m[MCR_IR] | q.serial_in;
		cexp.rx_ir = m[MCR_IR] & (q.serial_in ^ c[CFG_RXINV]);
		cexp.tx_allow = !(e[EFR_ACTS] & i[IER_ACTS]) | !q.cts_n;
	endfunction : cexp
	task automatic chk_all;
		for (int c = 0; c < NCH; c++)
		begin
			chk_val({24'h0, pin_o[c]}, {24'h0, pexp(rg[c][0], rg[c][1], rg[c][2], rg[c][3], core_i[c])});
			chk_val({29'h0, to_core[c]}, {29'h0, cexp(rg[c][0], rg[c][1], rg[c][2], rg[c][3], pin_i[c])});
			apb(1'b0, 32'(OFF_STAT + OFF_CHB * c), '0);
			chk_val(rd, {27'h0, pin_i[c].serial_in, ~pin_i[c].ri_n, ~pin_i[c].cd_n, ~pin_i[c].dsr_n, ~pin_i[c].cts_n});
			apb(1'b0, 32'(OFF_MCR + OFF_CHB * c), '0);
			chk_val(rd, {24'h0, rg[c][0]});
		end
		chk_val({30'h0, irq_line_a, irq_line_a_oe}, {30'h0, core_i[0].irq, rg[0][0][MCR_OP2]});
		chk_val({30'h0, irq_line_b, irq_line_b_oe}, {30'h0, core_i[1].irq, rg[1][0][MCR_OP2]});
	endtask : chk_all
	initial
	begin
		#200000;
		miscompares++;
		give_verdict;
	end
	initial
	begin
		void'($urandom(42));
		repeat (12) @(posedge pclk);
		chk_val({16'h0, pin_o}, {2{PIN_OUT_RST}});
		chk_val({26'h0, to_core}, {2{TO_CORE_RST}});
		presetn <= 1'b1;
		apb(1'b0, 32'(OFF_GLB), '0);
		chk_val(rd, 32'h1);
		apb(1'b1, 32'h100, '1);
		chk_val({31'h0, err}, 32'h1);
		apb(1'b0, 32'h3C, '0);
		chk_val({31'h0, err}, 32'h1);
		$display("test reset and unmapped done");
		// First two passes are the all-clear and all-set corners
		for (int n = 0; n < 40; n++)
		begin
			for (int c = 0; c < NCH; c++)
				for (int r = 0; r < 4; r++)
				begin
					rg[c][r] = (n < 2) ? {8{n[0]}} : 8'($urandom);
					apb(1'b1, 32'(OFF_CHB * c + 4 * r), {24'($urandom), rg[c][r]});
				end
			core_set <= 16'($urandom);
			pin_set <= 10'($urandom);
			ir_mode <= {rg[1][0][MCR_IR], rg[0][0][MCR_IR]};
			line_idle <= n[0];
			repeat (5) @(posedge pclk);
			chk_all;
		end
		$display("test random modes done");
		reset_pin <= 1'b1;
		repeat (5) @(posedge pclk);
		chk_val({31'h0, chip_rst}, 32'h1);
		chk_val({16'h0, pin_o & 16'hF7F7}, {2{PIN_OUT_RST}});
		reset_pin <= 1'b0;
		repeat (10) @(posedge pclk);
		rg = '{default: '0};
		chk_all;
		$display("test reset pin done");
		bus_sel_pin <= 1'b0;
		reset_pin <= 1'b1;
		repeat (12) @(posedge pclk);
		chk_val({31'h0, host_style_first}, 32'h0);
		chk_val({30'h0, irq_line_a, irq_line_a_oe}, {30'h0, !core_i[0].tx_rdy, 1'b1});
		apb(1'b0, 32'(OFF_GLB), '0);
		chk_val(rd, 32'h0);
		reset_pin <= 1'b0;
		repeat (4) @(posedge pclk);
		chk_val({31'h0, chip_rst}, 32'h1);
		$display("test bus style done");
		give_verdict;
	end
endmodule : dual_uart_pin_function_select_tb
`default_nettype wire
